// ---- include/pgo_map.svh ----
// Register offsets, field positions, reset values and calibration constants
`ifndef PGO_MAP_SVH
`define PGO_MAP_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PGO_CTRL_OFS 12'h000
`define PGO_GAIN_OFS 12'h010
`define PGO_SHIFT_OFS 12'h020
`define PGO_UDOFS_OFS 12'h030
`define PGO_EOFS_OFS 12'h034
`define PGO_TPG_OFS 12'h038
`define PGO_TPR_OFS 12'h03c
`define PGO_TPB_OFS 12'h040
`define PGO_TDATA_OFS 12'h044
`define PGO_BARW_OFS 12'h048
`define PGO_STAT_OFS 12'h04c
`define PGO_GROUP_MASK 12'hff0
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PGO_CTRL_MANUAL 0
`define PGO_CTRL_GLOCK 1
`define PGO_CTRL_RBLOCK 2
`define PGO_CTRL_TPEN 3
`define PGO_CTRL_ROWCAL 4
`define PGO_CTRL_EOMAN 5
`define PGO_CTRL_MODE_LSB 8
`define PGO_CTRL_MASK 32'h0000_0f3f
// ----------------------------------------------------------------------
// Reset values and calibration targets
// ----------------------------------------------------------------------
`define PGO_CTRL_RST 32'h0000_0010
`define PGO_GAIN_RST 14'h0800
`define PGO_SHIFT_RST 8'h80
`define PGO_BARW_RST 8'h10
`define PGO_BLC_LO 12'h0a0
`define PGO_BLC_HI 12'h0b0
`define PGO_ROW_TARGET 12'h0a8
`define PGO_BLC_NSHIFT 4
`define PGO_ROW_NSHIFT 3
`endif

// ---- include/pgo_pkg.sv ----
// Types shared by the pixel gain, offset and test pattern path
package pgo_pkg;
  typedef logic [11:0] pgo_pix_t;
  typedef logic [7:0] pgo_shift_t;
  typedef struct packed {
    logic fv;
    logic lv;
    logic dark_row;
    logic dark_col;
    pgo_pix_t data;
  } pgo_pix_s;
  typedef struct packed {
    logic fv;
    logic lv;
    logic valid;
    pgo_pix_t data;
  } pgo_out_s;
  typedef struct packed {
    logic [5:0] coarse;
    logic dbl;
    logic [6:0] fine;
  } pgo_gain_s;
  typedef struct packed {
    pgo_shift_t shift;
    logic [6:0] again;
  } pgo_ana_s;
  typedef struct packed {
    logic fv;
    logic lv;
    logic dark_col;
    logic [1:0] ch;
    logic col1;
    pgo_pix_t data;
  } pgo_stage_s;
  typedef enum logic [3:0] {
    PGO_TP_FIELD, PGO_TP_HGRAD, PGO_TP_VGRAD, PGO_TP_DIAG, PGO_TP_CLASSIC,
    PGO_TP_WALK, PGO_TP_HBARS, PGO_TP_VBARS, PGO_TP_CBARS
  } pgo_tp_e;
endpackage : pgo_pkg

// ---- hw/pgo_path.sv ----
// Pixel datapath: test patterns, digital gain, black level loops, offsets
`timescale 1ns/1ps
`include "pgo_map.svh"
module pgo_path #(
  parameter int BLC_NSHIFT = `PGO_BLC_NSHIFT,
  parameter int ROW_NSHIFT = `PGO_ROW_NSHIFT
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pgo_pkg::pgo_pix_s pix_in,
  output pgo_pkg::pgo_out_s pix_out,
  output pgo_pkg::pgo_ana_s [3:0] ana_ctl
);
  import pgo_pkg::*;

  if (BLC_NSHIFT < 1 || BLC_NSHIFT > 6 || ROW_NSHIFT < 1 || ROW_NSHIFT > 6)
  begin : g_bad_param
    $error("pgo_path: sample shifts must lie in 1..6");
  end

  localparam logic [6:0] BLC_N = 7'(1 << BLC_NSHIFT);
  localparam logic [6:0] ROW_N = 7'(1 << ROW_NSHIFT);

  // --------------------------------------------------------------------
  // Registers and bus decode
  // --------------------------------------------------------------------
  logic [31:0] ctrl;
  pgo_gain_s [3:0] gain;
  pgo_shift_t [3:0] shift_wr;
  pgo_shift_t [3:0] shift_use;
  pgo_shift_t [3:0] shift_eff;
  logic signed [11:0] user_dofs;
  logic signed [11:0] eo_man;
  pgo_pix_t tp_g, tp_r, tp_b, tdata;
  logic [7:0] barw;
  logic [7:0] frame_cnt;
  logic g_act, rb_act, manual_d;
  logic [31:0] rd_val;
  logic hit;
  logic [1:0] idx;
  logic wr_en, sh_wr, manual;

  function automatic logic [6:0] again_f(input pgo_gain_s g);
    again_f = 7'({1'b0, g.coarse} << g.dbl);
  endfunction : again_f

  assign idx = paddr[3:2];
  assign manual = ctrl[`PGO_CTRL_MANUAL];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_en = psel && penable && pwrite && hit;
  assign sh_wr = wr_en && (paddr & `PGO_GROUP_MASK) == `PGO_SHIFT_OFS;

  always_comb
  begin
    rd_val = '0;
    hit = 1'b1;
    if ((paddr & `PGO_GROUP_MASK) == `PGO_GAIN_OFS)
      rd_val = {16'(again_f(gain[idx]) * (8'h08 + 8'(gain[idx].fine))),
                1'b0, gain[idx].fine, 1'b0, gain[idx].dbl, gain[idx].coarse};
    else if ((paddr & `PGO_GROUP_MASK) == `PGO_SHIFT_OFS)
      rd_val = 32'(shift_eff[idx]);
    else
      unique case (paddr)
        `PGO_CTRL_OFS: rd_val = ctrl;
        `PGO_UDOFS_OFS: rd_val = 32'(unsigned'(user_dofs));
        `PGO_EOFS_OFS: rd_val = 32'(unsigned'(eo_man));
        `PGO_TPG_OFS: rd_val = 32'(tp_g);
        `PGO_TPR_OFS: rd_val = 32'(tp_r);
        `PGO_TPB_OFS: rd_val = 32'(tp_b);
        `PGO_TDATA_OFS: rd_val = 32'(tdata);
        `PGO_BARW_OFS: rd_val = 32'(barw);
        `PGO_STAT_OFS: rd_val = {22'h0, rb_act, g_act, frame_cnt};
        default: hit = 1'b0;
      endcase
    if (paddr[1:0] != 2'b00)
      hit = 1'b0;
  end

  // Read data is captured in the setup cycle so it is a flop in access
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= hit ? rd_val : '0;

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      ctrl <= `PGO_CTRL_RST;
      gain <= {4{`PGO_GAIN_RST}};
      user_dofs <= '0;
      eo_man <= '0;
      tp_g <= '0;
      tp_r <= '0;
      tp_b <= '0;
      tdata <= '0;
      barw <= `PGO_BARW_RST;
    end
    else if (wr_en)
    begin
      if ((paddr & `PGO_GROUP_MASK) == `PGO_GAIN_OFS)
        gain[idx] <= {pwdata[5:0], pwdata[6], pwdata[14:8]};
      else
        unique case (paddr)
          `PGO_CTRL_OFS: ctrl <= pwdata & `PGO_CTRL_MASK;
          `PGO_UDOFS_OFS: user_dofs <= pwdata[11:0];
          `PGO_EOFS_OFS: eo_man <= pwdata[11:0];
          `PGO_TPG_OFS: tp_g <= pwdata[11:0];
          `PGO_TPR_OFS: tp_r <= pwdata[11:0];
          `PGO_TPB_OFS: tp_b <= pwdata[11:0];
          `PGO_TDATA_OFS: tdata <= pwdata[11:0];
          `PGO_BARW_OFS: barw <= pwdata[7:0];
          default: ;
        endcase
    end

  // --------------------------------------------------------------------
  // Frame, line and pattern counters
  // --------------------------------------------------------------------
  logic fv_d, lv_d, fs, fe, ls, le, dark;
  logic [11:0] col_q, row_q, cur_col, walk_q, cur_walk;
  logic [7:0] vb_cnt, hb_cnt, cur_vb_cnt;
  logic [2:0] vb_idx, hb_idx, cur_vb_idx;
  logic [1:0] ch;

  assign fs = pix_in.fv && !fv_d;
  assign fe = !pix_in.fv && fv_d;
  assign ls = pix_in.lv && !lv_d;
  assign le = !pix_in.lv && lv_d;
  assign dark = pix_in.dark_row || pix_in.dark_col;
  assign cur_col = ls ? 12'h000 : col_q;
  assign cur_walk = ls ? 12'h001 : walk_q;
  assign cur_vb_cnt = ls ? 8'h00 : vb_cnt;
  assign cur_vb_idx = ls ? 3'h0 : vb_idx;
  assign ch = {row_q[0], cur_col[0]};

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      {fv_d, lv_d} <= 2'b00;
      {col_q, row_q, walk_q} <= '0;
      {vb_cnt, hb_cnt, vb_idx, hb_idx} <= '0;
      frame_cnt <= '0;
    end
    else
    begin
      fv_d <= pix_in.fv;
      lv_d <= pix_in.lv;
      if (fe)
        frame_cnt <= frame_cnt + 8'h01;
      if (pix_in.lv)
      begin
        col_q <= cur_col + 12'h001;
        walk_q <= {cur_walk[10:0], cur_walk[11]};
        vb_cnt <= (cur_vb_cnt + 8'h01 >= barw) ? 8'h00 : cur_vb_cnt + 8'h01;
        vb_idx <= cur_vb_idx + 3'((cur_vb_cnt + 8'h01 >= barw) ? 1 : 0);
      end
      if (fe)
      begin
        row_q <= '0;
        {hb_cnt, hb_idx} <= '0;
      end
      else if (le)
      begin
        row_q <= row_q + 12'h001;
        hb_cnt <= (hb_cnt + 8'h01 >= barw) ? 8'h00 : hb_cnt + 8'h01;
        hb_idx <= hb_idx + 3'((hb_cnt + 8'h01 >= barw) ? 1 : 0);
      end
    end

  // --------------------------------------------------------------------
  // Test pattern source
  // --------------------------------------------------------------------
  pgo_pix_t cf, pat, src;
  logic bar_on;
  always_comb
  begin
    unique case (ch)
      2'd1: cf = tp_r;
      2'd2: cf = tp_b;
      default: cf = tp_g;
    endcase
    unique case (ch)
      2'd1: bar_on = !cur_vb_idx[1];
      2'd2: bar_on = !cur_vb_idx[0];
      default: bar_on = !cur_vb_idx[2];
    endcase
    case (pgo_tp_e'(ctrl[`PGO_CTRL_MODE_LSB +: 4]))
      PGO_TP_HGRAD: pat = cur_col;
      PGO_TP_VGRAD: pat = row_q;
      PGO_TP_DIAG: pat = 12'(cur_col + row_q);
      PGO_TP_CLASSIC: pat = cur_col[0] ? ~tdata : tdata;
      PGO_TP_WALK: pat = cur_walk;
      PGO_TP_HBARS: pat = hb_idx[0] ? tp_b : tp_g;
      PGO_TP_VBARS: pat = cur_vb_idx[0] ? tp_b : tp_g;
      PGO_TP_CBARS: pat = bar_on ? 12'hfff : 12'h000;
      default: pat = cf;
    endcase
    // Dark pixels keep the colour values so black loops stay predictable
    if (!ctrl[`PGO_CTRL_TPEN])
      src = pix_in.data;
    else
      src = dark ? cf : pat;
  end

  // --------------------------------------------------------------------
  // Analog black level loop
  // --------------------------------------------------------------------
  logic [3:0][17:0] bsum;
  logic signed [3:0][17:0] bdiff;
  logic [3:0][6:0] bcnt;
  logic signed [3:0][11:0] eo_auto;

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      {bsum, bdiff, bcnt} <= '0;
      eo_auto <= '0;
    end
    else if (fs)
      {bsum, bdiff, bcnt} <= '0;
    else if (pix_in.lv && pix_in.dark_row && !pix_in.dark_col && !manual
             && bcnt[ch] < BLC_N)
    begin
      bsum[ch] <= bsum[ch] + 18'(pix_in.data);
      bdiff[ch] <= cur_col[1] ? bdiff[ch] - 18'(pix_in.data)
                              : bdiff[ch] + 18'(pix_in.data);
      bcnt[ch] <= bcnt[ch] + 7'h01;
    end
    else if (fe)
      for (int c = 0; c < 4; c++)
        if (bcnt[c] == BLC_N)
          eo_auto[c] <= 12'($signed(bdiff[c]) >>> (BLC_NSHIFT + 1));

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      shift_use <= {4{`PGO_SHIFT_RST}};
      shift_wr <= {4{`PGO_SHIFT_RST}};
      manual_d <= 1'b0;
    end
    else
    begin
      manual_d <= manual;
      if (manual && !manual_d)
        shift_use <= shift_wr;
      else if (sh_wr)
      begin
        shift_wr[idx] <= pwdata[7:0];
        if (manual)
          shift_use[idx] <= pwdata[7:0];
      end
      else if (fe && !manual)
        for (int c = 0; c < 4; c++)
          if (bcnt[c] == BLC_N)
          begin
            // One code step moves black by a few output codes, so step once
            if (12'(bsum[c] >> BLC_NSHIFT) < `PGO_BLC_LO && shift_use[c] != 8'hff)
              shift_use[c] <= shift_use[c] + 8'h01;
            else if (12'(bsum[c] >> BLC_NSHIFT) > `PGO_BLC_HI
                     && shift_use[c] != 8'h00)
              shift_use[c] <= shift_use[c] - 8'h01;
          end
    end

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      {g_act, rb_act} <= 2'b00;
    else if (fs)
    begin
      g_act <= ctrl[`PGO_CTRL_GLOCK] && gain[0].coarse == gain[3].coarse
               && gain[0].dbl == gain[3].dbl;
      rb_act <= ctrl[`PGO_CTRL_RBLOCK] && gain[1].coarse == gain[2].coarse
                && gain[1].dbl == gain[2].dbl;
    end

  assign shift_eff[0] = shift_use[0];
  assign shift_eff[1] = shift_use[1];
  assign shift_eff[2] = rb_act ? shift_use[1] : shift_use[2];
  assign shift_eff[3] = g_act ? shift_use[0] : shift_use[3];

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      ana_ctl <= '0;
    else
      for (int c = 0; c < 4; c++)
        ana_ctl[c] <= {shift_eff[c], again_f(gain[c])};

  // --------------------------------------------------------------------
  // Digital pipeline: source, gain, offset
  // --------------------------------------------------------------------
  pgo_stage_s s1, s2;
  logic [19:0] prod;
  logic gain_over;
  logic signed [13:0] tot_ofs, sum;
  logic signed [11:0] eo_sel, dofs;
  logic [3:0][11:0] rsum;
  logic [1:0][6:0] rcnt;
  logic signed [3:0][11:0] row_ofs;
  logic row_upd;
  logic [11:0] row_new;

  // Offset of a fresh row applies to its first active pixel as well
  assign row_upd = s2.lv && !s2.dark_col && rcnt[s2.ch[0]] == ROW_N;
  assign row_new = `PGO_ROW_TARGET - rsum[s2.ch[0]];

  assign prod = 20'(s1.data) * 20'(8'h08 + 8'(gain[s1.ch].fine));
  assign gain_over = |prod[19:15];

  always_comb
  begin
    eo_sel = ctrl[`PGO_CTRL_EOMAN] ? eo_man : eo_auto[s2.ch];
    if (!ctrl[`PGO_CTRL_ROWCAL])
      dofs = user_dofs;
    else if (row_upd)
      dofs = row_new;
    else
      dofs = row_ofs[s2.ch];
    tot_ofs = 14'(dofs) + (s2.col1 ? 14'(eo_sel) : -14'(eo_sel));
    if (tot_ofs > 14'sd2047)
      tot_ofs = 14'sd2047;
    else if (tot_ofs < -14'sd2048)
      tot_ofs = -14'sd2048;
    if (s2.dark_col)
      tot_ofs = '0;
    sum = 14'(s2.data) + tot_ofs;
  end

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      s1 <= '0;
      s2 <= '0;
      pix_out <= '0;
    end
    else
    begin
      s1 <= {pix_in.fv, pix_in.lv, pix_in.dark_col, ch, cur_col[1], src};
      s2 <= s1;
      s2.data <= gain_over ? 12'hfff : prod[14:3];
      pix_out.fv <= s2.fv;
      pix_out.lv <= s2.lv;
      pix_out.valid <= s2.lv;
      if (sum < 0)
        pix_out.data <= 12'h000;
      else if (sum > 14'sd4095)
        pix_out.data <= 12'hfff;
      else
        pix_out.data <= sum[11:0];
    end

  // Row loop averages gained dark columns, so it also cancels gain shift
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      {rsum, rcnt} <= '0;
      row_ofs <= '0;
    end
    else if (!s2.lv)
      {rsum, rcnt} <= '0;
    else if (s2.dark_col && rcnt[s2.ch[0]] < ROW_N)
    begin
      rsum[s2.ch[0]] <= rsum[s2.ch[0]] + 12'(s2.data >> ROW_NSHIFT);
      rcnt[s2.ch[0]] <= rcnt[s2.ch[0]] + 7'h01;
    end
    else if (row_upd)
      row_ofs[s2.ch] <= row_new;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_clip;
    s1.lv && gain_over |=> s2.data == 12'hfff;
  endproperty
  a_clip: assert property (p_clip) else $error("gain overflow not clipped");
  property p_unity;
    s1.lv && gain[s1.ch].fine == 7'h00 |=> s2.data == $past(s1.data);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain altered");
  property p_lat;
    pix_in.lv |-> ##3 pix_out.valid;
  endproperty
  a_lat: assert property (p_lat) else $error("pixel lost in pipeline");
  property p_glock;
    g_act |=> ana_ctl[3].shift == ana_ctl[0].shift;
  endproperty
  a_glock: assert property (p_glock) else $error("green lock broken");
  property p_rblock;
    rb_act |=> ana_ctl[2].shift == ana_ctl[1].shift;
  endproperty
  a_rblock: assert property (p_rblock) else $error("red-blue lock broken");
  property p_man;
    manual && manual_d && !sh_wr |=> shift_use == $past(shift_use);
  endproperty
  a_man: assert property (p_man) else $error("offset moved in manual");
  property p_hold;
    !manual && sh_wr && !fe |=> shift_use == $past(shift_use);
  endproperty
  a_hold: assert property (p_hold) else $error("auto write took effect");
  property p_dark;
    ctrl[`PGO_CTRL_TPEN] && pix_in.lv && dark && ch == 2'd0
      |=> s1.data == $past(tp_g);
  endproperty
  a_dark: assert property (p_dark) else $error("dark pixel not green");
  property p_walk;
    ctrl[`PGO_CTRL_TPEN] && ls && !dark
      && ctrl[`PGO_CTRL_MODE_LSB +: 4] == 4'h5 |=> s1.data == 12'h001;
  endproperty
  a_walk: assert property (p_walk) else $error("walk not started at one");
  property p_classic;
    ctrl[`PGO_CTRL_TPEN] && pix_in.lv && !dark && !cur_col[0]
      && ctrl[`PGO_CTRL_MODE_LSB +: 4] == 4'h4 |=> s1.data == $past(tdata);
  endproperty
  a_classic: assert property (p_classic) else $error("classic data wrong");
endmodule : pgo_path

// ---- sim/pgo_sink.sv ----
// Downstream capture model that collects corrected pixel words
`timescale 1ns/1ps
module pgo_sink (
  input wire logic clk_sys,
  input wire pgo_pkg::pgo_out_s pix
);
  import pgo_pkg::*;
  pgo_pix_t got[$];
  // Takes every valid beat; the real receiver cannot stall the stream
  always @(posedge clk_sys)
  begin
    if (pix.valid === 1'b1)
    begin
      got.push_back(pix.data);
    end
  end
endmodule : pgo_sink

// ---- sim/tb.sv ----
// Self-checking bench for the pixel gain, offset and test pattern path
`timescale 1ns/1ps
`include "pgo_map.svh"
module tb;
  import pgo_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pgo_pix_s pix_in = '0;
  pgo_out_s pix_out;
  pgo_ana_s [3:0] ana_ctl;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  always #25 clk_sys = ~clk_sys;
  // Small sample counts keep calibration frames short
  pgo_path #(.BLC_NSHIFT(1), .ROW_NSHIFT(1)) u_pgo_path (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_in(pix_in),
    .pix_out(pix_out), .ana_ctl(ana_ctl)
  );
  pgo_sink u_pgo_sink (.clk_sys(clk_sys), .pix(pix_out));
  // ----------------------------------------------------------------------
  // Bus, stream and compare helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string what, input logic [11:0] a,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  function automatic logic [31:0] q(input int i);
    return {20'h0, u_pgo_sink.got[i]};
  endfunction : q
  // Two rows of eight pixels; ndc leading pixels are dark columns
  task automatic frame(input logic [1:0] dk, input int ndc,
    input pgo_pix_t dd, input pgo_pix_t d);
    @(posedge clk_sys);
    u_pgo_sink.got.delete();
    pix_in.fv <= 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 9; i++)
      begin
        @(posedge clk_sys);
        pix_in <= '{1'b1, i < 8, dk[r], i < ndc,
          i == 8 ? ~d : (i < ndc ? dd : d)};
      end
    end
    repeat (4) @(posedge clk_sys);
    pix_in <= '{1'b0, 1'b0, 1'b0, 1'b0, d};
    repeat (4) @(posedge clk_sys);
  endtask : frame
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rdchk("ctrl", `PGO_CTRL_OFS, 32'h0000_0010);
    rdchk("gain", `PGO_GAIN_OFS, 32'h0040_0008);
    rdchk("shift", `PGO_SHIFT_OFS, 32'h0000_0080);
    chk("ana", 32'h4008, {17'h0, ana_ctl[0]});
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    wr(12'h001, 32'hffff);
    rdchk("misaligned", `PGO_CTRL_OFS, 32'h0000_0010);
  endtask : t_reset
  task automatic t_patterns;
    wr(`PGO_TPG_OFS, 32'h0a5);
    wr(`PGO_TPR_OFS, 32'h05a);
    wr(`PGO_TPB_OFS, 32'h3c3);
    wr(`PGO_TDATA_OFS, 32'h123);
    wr(`PGO_BARW_OFS, 32'h1);
    wr(`PGO_UDOFS_OFS, 32'h0);
    wr(`PGO_EOFS_OFS, 32'h0);
    for (int m = 0; m < 9; m++)
    begin
      // Calibration stays manual so patterns pass unaltered
      wr(`PGO_CTRL_OFS, 32'h29 | (32'(m) << 8));
      frame({1'b0, m == 4}, 0, 12'h0, 12'h7ff);
      case (m)
        0: chk("field", 32'h3c3, q(8));
        1: chk("hgrad", q(1) + 1, q(2));
        2: chk("vgrad", q(0) + 1, q(8));
        4: chk("classic", 32'hedc, q(9));
        5: chk("walk", 32'h4, q(2));
        6: chk("hbars", 32'h3c3, q(8));
        7: chk("vbars", 32'h3c3, q(1));
        8: chk("cbars", 32'h0, q(3));
        default: chk("count", 32'h10, 32'(u_pgo_sink.got.size()));
      endcase
      if (m == 4)
        chk("dark", 32'h05a, q(1));
      if (m == 5)
        chk("walk start", 32'h1, q(8));
    end
  endtask : t_patterns
  task automatic t_gain;
    wr(`PGO_CTRL_OFS, 32'h29);
    wr(`PGO_GAIN_OFS, 32'h0808);
    wr(`PGO_GAIN_OFS + 12'h8, 32'h7860);
    wr(`PGO_UDOFS_OFS, 32'h5);
    rdchk("total", `PGO_GAIN_OFS, 32'h0080_0808);
    frame(2'b00, 0, 12'h0, 12'h7ff);
    chk("g1", 32'h14f, q(0));
    chk("red", 32'h05f, q(1));
    chk("blue", 32'hfff, q(8));
    chk("g2", 32'h0aa, q(9));
    wr(`PGO_UDOFS_OFS, 32'h800);
    frame(2'b00, 0, 12'h0, 12'h7ff);
    chk("floor", 32'h0, q(1));
    wr(`PGO_GAIN_OFS + 12'h4, 32'h004a);
    repeat (2) @(posedge clk_sys);
    chk("again", 32'h14, {25'h0, ana_ctl[1].again});
  endtask : t_gain
  task automatic t_lock;
    wr(`PGO_CTRL_OFS, 32'h03);
    wr(`PGO_GAIN_OFS, 32'h0008);
    wr(`PGO_GAIN_OFS + 12'hc, 32'h0008);
    wr(`PGO_GAIN_OFS + 12'h8, 32'h004a);
    wr(`PGO_SHIFT_OFS, 32'h90);
    wr(`PGO_SHIFT_OFS + 12'h4, 32'h60);
    wr(`PGO_SHIFT_OFS + 12'h8, 32'h50);
    wr(`PGO_SHIFT_OFS + 12'hc, 32'h70);
    frame(2'b00, 0, 12'h0, 12'h100);
    chk("g2 lock", 32'h90, {24'h0, ana_ctl[3].shift});
    rdchk("g2 read", `PGO_SHIFT_OFS + 12'hc, 32'h90);
    rdchk("status", `PGO_STAT_OFS, 32'h0000_010c);
    wr(`PGO_CTRL_OFS, 32'h05);
    frame(2'b00, 0, 12'h0, 12'h100);
    chk("g2 free", 32'h70, {24'h0, ana_ctl[3].shift});
    chk("b lock", 32'h60, {24'h0, ana_ctl[2].shift});
    wr(`PGO_GAIN_OFS + 12'h8, 32'h000a);
    frame(2'b00, 0, 12'h0, 12'h100);
    chk("b free", 32'h50, {24'h0, ana_ctl[2].shift});
  endtask : t_lock
  task automatic t_hold;
    wr(`PGO_CTRL_OFS, 32'h00);
    wr(`PGO_SHIFT_OFS + 12'h4, 32'h33);
    rdchk("held", `PGO_SHIFT_OFS + 12'h4, 32'h60);
    wr(`PGO_CTRL_OFS, 32'h01);
    rdchk("loaded", `PGO_SHIFT_OFS + 12'h4, 32'h33);
  endtask : t_hold
  task automatic t_row;
    wr(`PGO_CTRL_OFS, 32'h31);
    frame(2'b00, 4, 12'h0a0, 12'h100);
    chk("row g1", 32'h108, q(4));
    chk("row b", 32'h108, q(12));
    chk("dark col", 32'h0a0, q(0));
    wr(`PGO_CTRL_OFS, 32'h21);
    wr(`PGO_UDOFS_OFS, 32'h3);
    wr(`PGO_EOFS_OFS, 32'h2);
    frame(2'b00, 4, 12'h0a0, 12'h100);
    chk("user", 32'h101, q(4));
    chk("odd path", 32'h105, q(6));
  endtask : t_row
  task automatic t_blc;
    wr(`PGO_CTRL_OFS, 32'h01);
    frame(2'b11, 0, 12'h0, 12'h010);
    chk("manual", 32'h90, {24'h0, ana_ctl[0].shift});
    wr(`PGO_CTRL_OFS, 32'h00);
    frame(2'b11, 0, 12'h0, 12'h010);
    chk("raise", 32'h91, {24'h0, ana_ctl[0].shift});
    chk("raise r", 32'h34, {24'h0, ana_ctl[1].shift});
    frame(2'b11, 0, 12'h0, 12'h0a8);
    chk("inside", 32'h91, {24'h0, ana_ctl[0].shift});
    frame(2'b11, 0, 12'h0, 12'h0c0);
    chk("lower", 32'h90, {24'h0, ana_ctl[0].shift});
  endtask : t_blc
  task automatic results;
    if (mismatches == 0 && n_tests > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // Run needs about 700 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_patterns;
    t_gain;
    t_lock;
    t_hold;
    t_row;
    t_blc;
    results;
  end
endmodule : tb
